// >>> acc_defines.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFS_CTRLA      8'h00
`define ACC_OFS_CTRLB      8'h01
`define ACC_OFS_CTRLC      8'h02
`define ACC_OFS_CTRLD      8'h03
`define ACC_OFS_CTRLE      8'h04
`define ACC_OFS_SAMPCTRL   8'h05
`define ACC_OFS_POSSEL     8'h08
`define ACC_OFS_NEGSEL     8'h09
`define ACC_OFS_COMMAND    8'h0a
`define ACC_OFS_EVCTRL     8'h0b
`define ACC_OFS_INTEN      8'h0c
`define ACC_OFS_FLAGS      8'h0d
`define ACC_OFS_DBGCTRL    8'h0e
`define ACC_OFS_RES_LO     8'h10
`define ACC_OFS_RES_HI     8'h11
`define ACC_OFS_WINLO_LO   8'h12
`define ACC_OFS_WINLO_HI   8'h13
`define ACC_OFS_WINHI_LO   8'h14
`define ACC_OFS_WINHI_HI   8'h15
`define ACC_OFS_STATUS     8'h16
`define ACC_BIT_ENABLE     0
`define ACC_BIT_FREERUN    1
`define ACC_BIT_DIFF       5
`define ACC_BIT_STBYRUN    7
`define ACC_BIT_START      0
`define ACC_BIT_READY      0
`define ACC_BIT_WINDOW     1
`define ACC_RST_BYTE       8'h00
`define ACC_CONV_CYCLES    5'd13
`define ACC_SEL_W          7
`endif

// >>> acc_pkg.sv
// Types shared by the converter control block
package acc_pkg;
	typedef enum logic [1:0] {ACC_IDLE, ACC_INIT, ACC_SAMPLE, ACC_CONVERT} acc_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} acc_bus_t;
	typedef struct packed {
		logic [6:0] pos;
		logic [6:0] neg;
	} acc_sel_t;
endpackage : acc_pkg

// >>> acc_conv_ctrl.sv
// Converter control: channel latching, start, accumulation, window compare, flags, sleep and debug
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_conv_ctrl (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire acc_pkg::acc_bus_t    bus,
	output logic [7:0]                rdata,
	input  wire logic                 start_event,
	input  wire logic [11:0]          sample_data,
	input  wire logic                 debug_halt,
	input  wire logic                 standby,
	input  wire logic                 power_down,
	output acc_pkg::acc_sel_t         active_sel,
	output logic                      sample_enable,
	output logic                      result_ready_event,
	output logic                      result_ready_irq,
	output logic                      window_match_irq,
	output logic                      clock_request
);
	import acc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  ctrla_q, ctrlb_q, ctrlc_q, ctrld_q, ctrle_q, sample_length_q, evctrl_q, inten_q, dbg_q;
	acc_sel_t    hold_sel_q;
	acc_sel_t    act_sel_q;
	logic        start_conversion_bit_q;
	logic [1:0]  flags_q;
	logic [15:0] res_q, winlo_q, winhi_q, acc_q;
	logic        res_invalid_q, halted_mid_q;
	logic        evt_q;
	logic [4:0]  prescale_q;
	logic [7:0]  cnt_q;
	logic [7:0]  nsamp_q;
	acc_state_t  state_q;
	logic        cclk_tick, run_ok, wr_cmd_start, evt_start, conv_done, win_hit;
	logic [4:0]  div_last;
	logic [7:0]  samp_total;

	wire wr_en = bus.wr;

	// Configuration writes; the command bit is handled with the converter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrla_q   <= `ACC_RST_BYTE;
			ctrlb_q   <= `ACC_RST_BYTE;
			ctrlc_q   <= `ACC_RST_BYTE;
			ctrld_q   <= `ACC_RST_BYTE;
			ctrle_q   <= `ACC_RST_BYTE;
			sample_length_q <= `ACC_RST_BYTE;
			evctrl_q  <= `ACC_RST_BYTE;
			inten_q   <= `ACC_RST_BYTE;
			dbg_q     <= `ACC_RST_BYTE;
			winlo_q   <= 16'h0000;
			winhi_q   <= 16'h0000;
		end else if (wr_en) begin
			case (bus.addr)
				`ACC_OFS_CTRLA:    ctrla_q   <= bus.wdata;
				`ACC_OFS_CTRLB:    ctrlb_q   <= {5'h00, bus.wdata[2:0]};
				`ACC_OFS_CTRLC:    ctrlc_q   <= {4'h0, bus.wdata[3:0]};
				`ACC_OFS_CTRLD:    ctrld_q   <= bus.wdata;
				`ACC_OFS_CTRLE:    ctrle_q   <= {5'h00, bus.wdata[2:0]};
				`ACC_OFS_SAMPCTRL: sample_length_q <= bus.wdata;
				`ACC_OFS_EVCTRL:   evctrl_q  <= {7'h00, bus.wdata[0]};
				`ACC_OFS_INTEN:    inten_q   <= {6'h00, bus.wdata[1:0]};
				`ACC_OFS_DBGCTRL:  dbg_q     <= {7'h00, bus.wdata[0]};
				`ACC_OFS_WINLO_LO: winlo_q[7:0]  <= bus.wdata;
				`ACC_OFS_WINLO_HI: winlo_q[15:8] <= bus.wdata;
				`ACC_OFS_WINHI_LO: winhi_q[7:0]  <= bus.wdata;
				`ACC_OFS_WINHI_HI: winhi_q[15:8] <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Holding register for the selections, written by software at any time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_sel_q <= '0;
		end else if (wr_en && bus.addr == `ACC_OFS_POSSEL) begin
			hold_sel_q.pos <= bus.wdata[6:0];
		end else if (wr_en && bus.addr == `ACC_OFS_NEGSEL) begin
			hold_sel_q.neg <= bus.wdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Run permission: power-down always freezes progress; debug halt and standby freeze it unless debug run or run-in-standby is set
	always_comb begin
		run_ok = ctrla_q[`ACC_BIT_ENABLE]
			&& !(debug_halt && !dbg_q[0])
			&& !(standby && !ctrla_q[`ACC_BIT_STBYRUN])
			&& !power_down;
	end

	// Converter clock enable from the prescaler: divide by 2,4,8,12..28
	always_comb begin
		case (ctrlc_q[2:0])
			3'h0:    div_last = 5'd1;
			3'h1:    div_last = 5'd3;
			3'h2:    div_last = 5'd7;
			3'h3:    div_last = 5'd11;
			3'h4:    div_last = 5'd15;
			3'h5:    div_last = 5'd19;
			3'h6:    div_last = 5'd23;
			default: div_last = 5'd27;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_q <= 5'd0;
		end else if (!run_ok || prescale_q >= div_last) begin
			prescale_q <= 5'd0;
		end else begin
			prescale_q <= prescale_q + 5'd1;
		end
	end
	assign cclk_tick = run_ok && (prescale_q >= div_last);

	////////////////////////////////////////////////////////////////////////////////
	// Start sources; the event is already synchronous, so edge detect directly
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_q <= 1'b0;
		end else begin
			evt_q <= start_event;
		end
	end
	assign evt_start    = evctrl_q[0] && start_event && !evt_q;
	assign wr_cmd_start = wr_en && bus.addr == `ACC_OFS_COMMAND && bus.wdata[`ACC_BIT_START];

	// Samples per result: 1 << accumulation number
	assign samp_total = 8'h01 << ctrlb_q[2:0];

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer; steps only on converter clock ticks
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ACC_IDLE;
			cnt_q   <= 8'h00;
			nsamp_q <= 8'h00;
		end else if (cclk_tick) begin
			case (state_q)
				ACC_IDLE: begin
					if (start_conversion_bit_q) begin
						nsamp_q <= 8'h00;
						if (ctrld_q[7:5] != 3'h0) begin
							state_q <= ACC_INIT;
							cnt_q   <= {5'h00, ctrld_q[7:5]} << 4;
						end else begin
							state_q <= ACC_SAMPLE;
							cnt_q   <= sample_length_q;
						end
					end
				end
				ACC_INIT: begin
					if (cnt_q == 8'h00) begin
						state_q <= ACC_SAMPLE;
						cnt_q   <= sample_length_q;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ACC_SAMPLE: begin
					if (cnt_q == 8'h00) begin
						state_q <= ACC_CONVERT;
						cnt_q   <= {3'h0, `ACC_CONV_CYCLES};
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ACC_CONVERT: begin
					if (cnt_q == 8'h00) begin
						nsamp_q <= nsamp_q + 8'h01;
						if (nsamp_q + 8'h01 < samp_total) begin
							state_q <= ACC_SAMPLE;
							cnt_q   <= sample_length_q;
						end else if (ctrla_q[`ACC_BIT_FREERUN]) begin
							state_q <= ACC_SAMPLE;
							nsamp_q <= 8'h00;
							cnt_q   <= sample_length_q;
						end else begin
							state_q <= ACC_IDLE;
						end
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: state_q <= ACC_IDLE;
			endcase
		end
	end

	// One sample's conversion ends on this tick
	wire samp_end = cclk_tick && state_q == ACC_CONVERT && cnt_q == 8'h00;
	assign conv_done = samp_end && (nsamp_q + 8'h01 >= samp_total);
	assign sample_enable = (state_q == ACC_SAMPLE);

	// Start bit: set by software or event, cleared when a result completes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_conversion_bit_q <= 1'b0;
		end else if (wr_cmd_start || evt_start) begin
			start_conversion_bit_q <= 1'b1;
		end else if (conv_done) begin
			start_conversion_bit_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Active selection copies holding register in idle, in init and at convert count zero; it holds while sampling and counting down
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_sel_q <= '0;
		end else if (state_q == ACC_IDLE || state_q == ACC_INIT
			|| (state_q == ACC_CONVERT && cnt_q == 8'h00)) begin
			act_sel_q.pos <= hold_sel_q.pos;
			act_sel_q.neg <= ctrla_q[`ACC_BIT_DIFF] ? hold_sel_q.neg : '0;
		end
	end
	assign active_sel = act_sel_q;

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator and result; a conversion interrupted by power-down marks the result invalid
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q         <= 16'h0000;
			res_q         <= 16'h0000;
			halted_mid_q  <= 1'b0;
			res_invalid_q <= 1'b0;
		end else begin
			if (power_down && state_q != ACC_IDLE) begin
				halted_mid_q <= 1'b1;
			end
			if (samp_end) begin
				if (nsamp_q == 8'h00) begin
					acc_q <= {4'h0, sample_data};
				end else begin
					acc_q <= acc_q + {4'h0, sample_data};
				end
			end
			if (conv_done) begin
				res_q         <= (nsamp_q == 8'h00) ? {4'h0, sample_data} : acc_q + {4'h0, sample_data};
				res_invalid_q <= halted_mid_q || (power_down && state_q != ACC_IDLE);
				halted_mid_q  <= 1'b0;
			end
		end
	end

	// Window test on the final total only
	wire [15:0] total = (nsamp_q == 8'h00) ? {4'h0, sample_data} : acc_q + {4'h0, sample_data};
	always_comb begin
		case (ctrle_q[2:0])
			3'h1:    win_hit = total < winlo_q;
			3'h2:    win_hit = total > winhi_q;
			3'h3:    win_hit = total > winlo_q && total < winhi_q;
			3'h4:    win_hit = total < winlo_q || total > winhi_q;
			default: win_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags: hardware set wins over a same-cycle write-one clear
	wire       flag_wr = wr_en && bus.addr == `ACC_OFS_FLAGS;
	wire [1:0] flag_set = {conv_done && win_hit, conv_done};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= 2'b00;
		end else begin
			flags_q <= flag_set | (flags_q & ~(flag_wr ? bus.wdata[1:0] : 2'b00));
		end
	end

	// Requests are levels held while flag and enable both stand
	assign result_ready_irq = flags_q[`ACC_BIT_READY] && inten_q[`ACC_BIT_READY];
	assign window_match_irq = flags_q[`ACC_BIT_WINDOW] && inten_q[`ACC_BIT_WINDOW];

	// Event pulse registered so it lasts exactly one clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result_ready_event <= 1'b0;
		end else begin
			result_ready_event <= conv_done;
		end
	end

	// Clock requested only while work is pending
	assign clock_request = ctrla_q[`ACC_BIT_ENABLE] && (start_conversion_bit_q || state_q != ACC_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// Read port, data in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`ACC_OFS_CTRLA:    rdata <= ctrla_q;
				`ACC_OFS_CTRLB:    rdata <= ctrlb_q;
				`ACC_OFS_CTRLC:    rdata <= ctrlc_q;
				`ACC_OFS_CTRLD:    rdata <= ctrld_q;
				`ACC_OFS_CTRLE:    rdata <= ctrle_q;
				`ACC_OFS_SAMPCTRL: rdata <= sample_length_q;
				`ACC_OFS_POSSEL:   rdata <= {1'b0, hold_sel_q.pos};
				`ACC_OFS_NEGSEL:   rdata <= {1'b0, hold_sel_q.neg};
				`ACC_OFS_COMMAND:  rdata <= {7'h00, start_conversion_bit_q};
				`ACC_OFS_EVCTRL:   rdata <= evctrl_q;
				`ACC_OFS_INTEN:    rdata <= inten_q;
				`ACC_OFS_FLAGS:    rdata <= {6'h00, flags_q};
				`ACC_OFS_DBGCTRL:  rdata <= dbg_q;
				`ACC_OFS_RES_LO:   rdata <= res_q[7:0];
				`ACC_OFS_RES_HI:   rdata <= res_q[15:8];
				`ACC_OFS_WINLO_LO: rdata <= winlo_q[7:0];
				`ACC_OFS_WINLO_HI: rdata <= winlo_q[15:8];
				`ACC_OFS_WINHI_LO: rdata <= winhi_q[7:0];
				`ACC_OFS_WINHI_HI: rdata <= winhi_q[15:8];
				`ACC_OFS_STATUS:   rdata <= {6'h00, res_invalid_q, state_q != ACC_IDLE};
				default:           rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_event_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
		result_ready_event |=> !result_ready_event)
		else $error("result event longer than one cycle");
	a_event_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(result_ready_event) |-> flags_q[`ACC_BIT_READY] && !start_conversion_bit_q)
		else $error("completion did not set flag or clear start");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
		result_ready_irq == (flags_q[0] && inten_q[0]))
		else $error("ready request mismatch");
	a_win_off: assert property (@(posedge clk) disable iff (!rst_b)
		(ctrle_q[2:0] == 3'h0) |=> !$rose(flags_q[`ACC_BIT_WINDOW]))
		else $error("window flag set while disabled");
	a_win_once: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(flags_q[`ACC_BIT_WINDOW]) |-> $past(conv_done))
		else $error("window flag set before accumulation end");
	a_sel_frozen: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ACC_SAMPLE && $past(state_q) == ACC_SAMPLE) |-> $stable(act_sel_q))
		else $error("selection changed during sampling");
	a_event_start: assert property (@(posedge clk) disable iff (!rst_b)
		evt_start |=> start_conversion_bit_q)
		else $error("event did not set start bit");
	a_debug_halt: assert property (@(posedge clk) disable iff (!rst_b)
		(debug_halt && !dbg_q[0]) |-> !cclk_tick)
		else $error("converter ran during debug halt");
	a_power_down: assert property (@(posedge clk) disable iff (!rst_b)
		power_down |=> $stable(state_q) && $stable(cnt_q))
		else $error("conversion progressed in power-down");
	a_standby: assert property (@(posedge clk) disable iff (!rst_b)
		(standby && !ctrla_q[`ACC_BIT_STBYRUN]) |-> !cclk_tick)
		else $error("converter ran in standby without permission");
endmodule : acc_conv_ctrl

// >>> acc_far_end.sv
// Far-side model: event router start pulses and converter sample source
`timescale 1ns/1ps

module acc_far_end (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        fire,
	input  wire logic [11:0] level,
	output logic             start_event,
	output logic [11:0]      sample_data
);
	logic [1:0] hold_q;

	////////////////////////////////////////////////////////////////////////////////
	// Router stretches a request into a two-cycle level so the rising edge is clean
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= 2'h0;
		end else if (fire) begin
			hold_q <= 2'h2;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end
	assign start_event = (hold_q != 2'h0);

	// Analog level held steady by the bench; the converter samples it at its own moment
	assign sample_data = level;
endmodule : acc_far_end

// >>> adc_conversion_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acc_defines.svh"

module adc_conversion_control_tb_top;
	import acc_pkg::*;
	logic        clk, rst_b, debug_halt, standby, power_down, fire;
	acc_bus_t    bus;
	logic [7:0]  rdata, d, p0, p1;
	logic [11:0] level, sample_data, s;
	logic        start_event, sample_enable, result_ready_event, result_ready_irq, window_match_irq, clock_request;
	acc_sel_t    active_sel;
	logic [15:0] res;
	int          fail_count, samples_checked, cyc_count, ev_count, t0, t1, n0;
	logic [11:0] corner [5] = '{12'h080, 12'h100, 12'h400, 12'h800, 12'hc00};

	acc_conv_ctrl dut_u (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .start_event(start_event),
		.sample_data(sample_data), .debug_halt(debug_halt), .standby(standby), .power_down(power_down),
		.active_sel(active_sel), .sample_enable(sample_enable), .result_ready_event(result_ready_event),
		.result_ready_irq(result_ready_irq), .window_match_irq(window_match_irq), .clock_request(clock_request));
	acc_far_end far_u (.clk(clk), .rst_b(rst_b), .fire(fire), .level(level), .start_event(start_event),
		.sample_data(sample_data));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, cycle ceiling and result pulse counter
	initial clk = 1'b0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc_count++;
		if (result_ready_event === 1'b1) ev_count++;
		if (cyc_count == 60000) begin
			fail_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	// Strobe is dropped and one idle cycle passes, so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 v = rdata;
		@(posedge clk);
	endtask : rd

	// Bounded wait for the result pulse, then confirm it lasted one cycle
	task automatic wait_done(output int n);
		n = 0;
		while (result_ready_event !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		chk(result_ready_event, 16'h1, "result event");
		@(posedge clk);
		#1 chk(result_ready_event, 16'h0, "event width");
		@(posedge clk);
	endtask : wait_done

	task automatic read_res;
		rd(`ACC_OFS_RES_LO, d);
		res[7:0] = d;
		rd(`ACC_OFS_RES_HI, d);
		res[15:8] = d;
	endtask : read_res

	task automatic run(input logic [11:0] v);
		level <= v;
		wr(`ACC_OFS_COMMAND, 8'h01);
		wait_done(t1);
		read_res();
	endtask : run

	// Expected window verdict: 1 below, 2 above, 3 inside, 4 outside, else off
	function automatic logic win_exp(input int m, input logic [15:0] r, input logic [15:0] lo, input logic [15:0] hi);
		case (m)
			1: return r < lo;
			2: return r > hi;
			3: return (r > lo) && (r < hi);
			4: return (r < lo) || (r > hi);
			default: return 1'b0;
		endcase
	endfunction : win_exp

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		rst_b = 1'b0;
		fire = 1'b0;
		level = 12'h000;
		debug_halt = 1'b0;
		standby = 1'b0;
		power_down = 1'b0;
		void'($urandom(15476));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Every byte place reads zero after reset, unmapped ones included
		for (int a = 0; a < 8'h18; a++) begin
			rd(a[7:0], d);
			chk(d, `ACC_RST_BYTE, "reset byte");
		end
		chk(clock_request, 16'h0, "idle clock request");
		chk(sample_enable, 16'h0, "idle sampling");
		$display("test reset done");

		// Selection follows writes while idle, freezes during conversion
		p0 = $urandom & 8'h7f;
		p1 = $urandom & 8'h7f;
		s = $urandom;
		wr(`ACC_OFS_POSSEL, p0);
		wr(`ACC_OFS_NEGSEL, p1);
		wr(`ACC_OFS_CTRLA, 8'h01);
		wr(`ACC_OFS_INTEN, 8'h01);
		chk(active_sel.pos, p0, "pos follows");
		chk(active_sel.neg, 16'h0, "neg unused");
		level <= s;
		wr(`ACC_OFS_COMMAND, 8'h01);
		wr(`ACC_OFS_POSSEL, p0 ^ 8'h55);
		chk(active_sel.pos, p0, "pos frozen");
		chk(clock_request, 16'h1, "busy clock request");
		rd(`ACC_OFS_COMMAND, d);
		chk(d, 16'h1, "start bit set");
		wait_done(t0);
		chk(active_sel.pos, p0 ^ 8'h55, "pos resumes");
		rd(`ACC_OFS_FLAGS, d);
		chk(d, 16'h1, "ready flag");
		rd(`ACC_OFS_COMMAND, d);
		chk(d, 16'h0, "start bit cleared");
		read_res();
		chk(res, s, "result");
		chk(result_ready_irq, 16'h1, "ready irq");
		wr(`ACC_OFS_FLAGS, 8'h00);
		chk(result_ready_irq, 16'h1, "zero write keeps");
		wr(`ACC_OFS_FLAGS, 8'h01);
		chk(result_ready_irq, 16'h0, "one write clears");
		chk(clock_request, 16'h0, "released clock");
		wr(`ACC_OFS_CTRLA, 8'h21);
		// The copy lands one edge after the mode write, so let it settle first
		@(posedge clk);
		chk(active_sel.neg, p1, "neg used");
		wr(`ACC_OFS_CTRLA, 8'h01);
		$display("test selection done");

		// Every window mode against corner and random results
		wr(`ACC_OFS_WINLO_HI, 8'h01);
		wr(`ACC_OFS_WINHI_HI, 8'h08);
		wr(`ACC_OFS_INTEN, 8'h03);
		for (int m = 0; m < 6; m++) begin
			for (int k = 0; k < 6; k++) begin
				s = (k == 5) ? 12'($urandom) : corner[k];
				wr(`ACC_OFS_FLAGS, 8'h03);
				wr(`ACC_OFS_CTRLE, m[7:0]);
				run(s);
				rd(`ACC_OFS_FLAGS, d);
				chk(d[1], win_exp(m, s, 16'h0100, 16'h0800), "window flag");
				chk(window_match_irq, win_exp(m, s, 16'h0100, 16'h0800), "window irq");
			end
		end
		$display("test window done");

		// Four samples summed; one sample stays below the high threshold, the four-sample total crosses it
		wr(`ACC_OFS_CTRLE, 8'h02);
		wr(`ACC_OFS_CTRLB, 8'h02);
		wr(`ACC_OFS_FLAGS, 8'h03);
		n0 = ev_count;
		run(12'h300);
		chk(res, 16'h0c00, "accumulated total");
		chk(ev_count - n0, 16'h1, "one result per group");
		rd(`ACC_OFS_FLAGS, d);
		chk(d[1], 16'h1, "total compared");
		wr(`ACC_OFS_CTRLB, 8'h00);
		$display("test accumulation done");

		// Event start honoured only when enabled
		n0 = ev_count;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (150) @(posedge clk);
		chk(ev_count - n0, 16'h0, "event ignored");
		wr(`ACC_OFS_EVCTRL, 8'h01);
		s = $urandom;
		level <= s;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wait_done(t1);
		read_res();
		chk(res, s, "event result");
		$display("test event done");

		// Debug halt holds the sequencer until debug run is set
		debug_halt <= 1'b1;
		n0 = ev_count;
		wr(`ACC_OFS_COMMAND, 8'h01);
		repeat (200) @(posedge clk);
		chk(ev_count - n0, 16'h0, "halted in debug");
		wr(`ACC_OFS_DBGCTRL, 8'h01);
		wait_done(t1);
		wr(`ACC_OFS_DBGCTRL, 8'h00);
		debug_halt <= 1'b0;
		$display("test debug done");

		// Standby without run-in-standby makes no progress; with it, events still convert
		standby <= 1'b1;
		n0 = ev_count;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (200) @(posedge clk);
		chk(ev_count - n0, 16'h0, "off in standby");
		standby <= 1'b0;
		repeat (200) @(posedge clk);
		standby <= 1'b1;
		wr(`ACC_OFS_CTRLA, 8'h81);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wait_done(t1);
		chk(clock_request, 16'h0, "standby clock released");
		standby <= 1'b0;
		wr(`ACC_OFS_EVCTRL, 8'h00);
		$display("test standby done");

		// Power-down in mid-conversion: resumes, flags ready, marks result invalid
		n0 = ev_count;
		wr(`ACC_OFS_COMMAND, 8'h01);
		repeat (8) @(posedge clk);
		power_down <= 1'b1;
		repeat (150) @(posedge clk);
		chk(ev_count - n0, 16'h0, "frozen in power-down");
		power_down <= 1'b0;
		wait_done(t1);
		rd(`ACC_OFS_STATUS, d);
		chk(d[1], 16'h1, "result invalid");
		$display("test power-down done");

		// Initialization delay lengthens the first conversion by sixteen ticks a step plus one tick
		wr(`ACC_OFS_SAMPCTRL, 8'h04);
		run(12'h123);
		t0 = t1;
		// Delay step one sits in the top three bits
		wr(`ACC_OFS_CTRLD, 8'h20);
		run(12'h123);
		chk(t1 >= t0 + 30, 16'h1, "init delay");
		// Sleep entered only after the result is in leaves it valid
		power_down <= 1'b1;
		repeat (4) @(posedge clk);
		power_down <= 1'b0;
		rd(`ACC_OFS_STATUS, d);
		chk(d[1], 16'h0, "finished before sleep");
		$display("test init delay done");
		test_done();
	end
endmodule : adc_conversion_control_tb_top
